//--- inc/pie_pkg.sv
// Operation
// R1: Mask read with code C3h, written with C2h, four data bytes each.
// R2: Bus reset leaves every interrupt mask bit unchanged.
// R3: Mask bits 23..10 gate endpoints 14..1, bit 9 control IN, 8 OUT.
// R4: Mask bit 6 gates the short packet interrupt.
// R5: Mask bit 5 gates the 1 ms pseudo frame interrupt.
// R6: Mask bit 4 gates frame start, bit 3 gates DMA end of transfer.
// R7: Mask bits 2, 1, 0 gate suspend, resume and bus reset.
// R8: Software writes zeros into reserved mask bits 31..24.
// R9: DMA configuration read with F1h, written with F0h, two bytes.
// R10: Bus reset clears DMA run bit only; other configuration bits kept.
// R11: Run bit 3 starts DMA, zero stops it, reads back running state.
// R12: With bit 15 set, counter reaching zero raises end of transfer.
// R13: With bit 14 set, short OUT packet raises end of transfer.
// R14: Software keeps short packet mode cleared for IN endpoints.
// R15: Bits 7..4 select the DMA target endpoint.
// R16: Burst bits 1..0 select 1, 4, 8 or 16 bytes.
// R17: Byte counter read with F3h, written with F2h, two bytes.
// R18: Counter write sets length; read returns bytes still remaining.
// R19: Bus reset leaves the programmed byte count unchanged.
// R20: Working counter reloads from the programmed count for each transfer.
// R21: DMA skips the two leading packet length bytes of a buffer.
// R22: External end of transfer on IN sends the partial buffer.
// R23: Multi byte accesses run low byte first, restarting per code.
// R24: Interrupt output asserts only for events whose enable is one.
package pie_pkg;
   localparam logic [7:0] PIE_CODE_MASK_RD = 8'hc3;
   localparam logic [7:0] PIE_CODE_MASK_WR = 8'hc2;
   localparam logic [7:0] PIE_CODE_CFG_RD = 8'hf1;
   localparam logic [7:0] PIE_CODE_CFG_WR = 8'hf0;
   localparam logic [7:0] PIE_CODE_CNT_RD = 8'hf3;
   localparam logic [7:0] PIE_CODE_CNT_WR = 8'hf2;
   localparam logic [2:0] PIE_MASK_BYTES = 3'h4;
   localparam logic [2:0] PIE_CFG_BYTES = 3'h2;
   localparam logic [2:0] PIE_CNT_BYTES = 3'h2;
   localparam int PIE_EPT_LSB = 8;
   localparam int PIE_EPT_MSB = 23;
   localparam int PIE_SHORT_BIT = 6;
   localparam int PIE_PSOF_BIT = 5;
   localparam int PIE_SOF_BIT = 4;
   localparam int PIE_EOT_BIT = 3;
   localparam int PIE_SUSP_BIT = 2;
   localparam int PIE_RESM_BIT = 1;
   localparam int PIE_BRST_BIT = 0;
   localparam int PIE_CNTEND_BIT = 15;
   localparam int PIE_SHORT_PACKET_END_MODE_BIT = 14;
   localparam int PIE_EPSEL_LSB = 4;
   localparam int PIE_RUN_BIT = 3;
   localparam int PIE_BURST_LSB = 0;
   localparam logic [31:0] PIE_MASK_WBITS = 32'h00ff_ff7f;
   localparam logic [15:0] PIE_CFG_WBITS = 16'hc0fb;
   localparam logic [31:0] PIE_MASK_RST = 32'h0000_0000;
   localparam logic [15:0] PIE_CFG_RST = 16'h0000;
   localparam logic [15:0] PIE_CNT_RST = 16'h0000;
   localparam logic [1:0] PIE_SKIP_BYTES = 2'h2;
   typedef enum {PIE_SEL_NONE, PIE_SEL_MASK, PIE_SEL_CFG, PIE_SEL_CNT}
      pie_sel_type;
endpackage

//--- inc/pie_fifo_if.sv
`timescale 1ns/100ps
interface pie_fifo_if #(parameter int WIDTH = 8, parameter int LVLW = 5);
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;
   logic flush;
   logic [LVLW-1:0] level;
   modport store (input push_valid, push_data, pop_ready, flush,
      output push_ready, pop_valid, pop_data, level);
   modport user (output push_valid, push_data, pop_ready, flush,
      input push_ready, pop_valid, pop_data, level);
endinterface

//--- hw/pie_fifo.sv
`timescale 1ns/100ps
module pie_fifo
   import pie_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int LVLW = $clog2(DEPTH) + 1
) (
   input wire logic i_mclk,    // Core clock
   input wire logic i_reset_n, // Async reset, active low
   pie_fifo_if.store fif       // Push and pop sides
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [LVLW-1:0] FULL = LVLW'(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [LVLW-1:0] lvl_r;
   logic do_push;
   logic do_pop;

   assign fif.push_ready = (lvl_r != FULL) && !fif.flush;
   assign fif.pop_valid = (lvl_r != '0) && !fif.flush;
   assign fif.pop_data = mem_r[rp_r];
   assign fif.level = lvl_r;
   assign do_push = fif.push_valid && fif.push_ready;
   assign do_pop = fif.pop_valid && fif.pop_ready;

   always_ff @(posedge i_mclk) begin
      if (do_push) begin
         mem_r[wp_r] <= fif.push_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wp_r <= '0;
         rp_r <= '0;
         lvl_r <= '0;
      end else if (fif.flush) begin
         wp_r <= '0;
         rp_r <= '0;
         lvl_r <= '0;
      end else begin
         if (do_push) begin
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (do_pop) begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         lvl_r <= lvl_r + LVLW'(do_push) - LVLW'(do_pop);
      end
   end
endmodule

//--- hw/pie_regs.sv
`timescale 1ns/100ps
module pie_regs
   import pie_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic i_mclk,             // Core clock, 100 MHz
   input wire logic i_reset_n,          // Async reset, active low
   input wire logic i_wr_valid,         // Host write strobe
   input wire logic i_wr_is_code,       // Strobe carries a command code
   input wire logic [7:0] i_wr_byte,    // Code or data byte
   input wire logic i_rd_req,           // Host read strobe
   output logic [7:0] o_rd_data,        // Read byte, valid with o_rd_valid
   output logic o_rd_valid,             // Read answer pulse
   input wire logic i_bus_reset,        // USB bus reset seen, pulse
   input wire logic [15:0] i_ev_endpt,  // Endpoint events, 0 = ctrl OUT
   input wire logic i_ev_short,         // Short packet detected
   input wire logic i_ev_pseudo_sof,    // Pseudo frame tick
   input wire logic i_ev_sof,           // Frame start received
   input wire logic i_ev_suspend,       // Suspend detected
   input wire logic i_ev_resume,        // Resume detected
   output logic o_irq,                  // Enabled event pulse
   input wire logic i_ep_start,         // New endpoint buffer begins
   input wire logic i_ep_is_in,         // DMA endpoint transmits
   input wire logic i_ep_valid,         // Endpoint buffer byte valid
   input wire logic [7:0] i_ep_data,    // Endpoint buffer byte
   output logic o_ep_ready,             // Endpoint byte accepted
   output logic o_dma_valid,            // DMA byte valid
   output logic [7:0] o_dma_data,       // DMA byte
   input wire logic i_dma_ready,        // DMA controller takes byte
   output logic o_dma_req,              // Enough bytes for a burst
   output logic [4:0] o_burst_bytes,    // Burst length in bytes
   output logic [3:0] o_dma_endpt,      // Target endpoint
   input wire logic i_ext_eot,          // External end of transfer
   output logic o_dma_eot,              // End of transfer pulse
   output logic o_send_partial          // Send IN buffer as it stands
);
   localparam int LVLW = $clog2(FIFO_DEPTH) + 1;

   pie_sel_type sel_r;
   logic rd_dir_r;
   logic [2:0] idx_r;
   logic [31:0] asm_r;
   logic [31:0] mask_r;
   logic [15:0] cfg_r;
   logic [15:0] prog_r;
   logic [15:0] cnt_r;
   logic [1:0] skip_r;
   logic [7:0] rd_data_r;
   logic rd_valid_r;
   logic irq_r;
   logic eot_r;
   logic partial_r;

   pie_sel_type code_sel;
   logic code_rd;
   logic [2:0] sel_len;
   logic data_wr;
   logic data_rd;
   logic commit;
   logic [31:0] wr_word;
   logic [31:0] rd_word;
   logic mask_wr;
   logic cfg_wr;
   logic cnt_wr;
   logic run;
   logic deliver;
   logic cnt_zero_eot;
   logic short_eot;
   logic any_eot;
   logic [23:0] events;
   logic [LVLW-1:0] burst_lvl;

   pie_fifo_if #(.WIDTH(8), .LVLW(LVLW)) fifo_bus ();

   pie_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .LVLW(LVLW)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .fif(fifo_bus.store)
   );

   // Command decode: a code byte selects register and direction
   always_comb begin
      code_sel = PIE_SEL_NONE;
      code_rd = 1'b0;
      case (i_wr_byte)
         PIE_CODE_MASK_RD: begin
            code_sel = PIE_SEL_MASK; // see R1
            code_rd = 1'b1;
         end
         PIE_CODE_MASK_WR: code_sel = PIE_SEL_MASK; // see R1
         PIE_CODE_CFG_RD: begin
            code_sel = PIE_SEL_CFG; // see R9
            code_rd = 1'b1;
         end
         PIE_CODE_CFG_WR: code_sel = PIE_SEL_CFG; // see R9
         PIE_CODE_CNT_RD: begin
            code_sel = PIE_SEL_CNT; // see R17
            code_rd = 1'b1;
         end
         PIE_CODE_CNT_WR: code_sel = PIE_SEL_CNT; // see R17
         default: code_sel = PIE_SEL_NONE;
      endcase
   end

   always_comb begin
      case (sel_r)
         PIE_SEL_MASK: sel_len = PIE_MASK_BYTES;
         PIE_SEL_CFG: sel_len = PIE_CFG_BYTES;
         PIE_SEL_CNT: sel_len = PIE_CNT_BYTES;
         default: sel_len = 3'h0;
      endcase
   end

   // Bytes beyond the register length are dropped, not wrapped
   assign data_wr = i_wr_valid && !i_wr_is_code && !rd_dir_r
      && (idx_r < sel_len);
   assign data_rd = i_rd_req && rd_dir_r && (idx_r < sel_len);
   assign commit = data_wr && (idx_r == sel_len - 3'h1);

   always_comb begin
      wr_word = asm_r;
      wr_word[{idx_r[1:0], 3'h0} +: 8] = i_wr_byte; // see R23
   end

   // Reads show the working counter, not the programmed count
   always_comb begin
      case (sel_r)
         PIE_SEL_MASK: rd_word = mask_r & PIE_MASK_WBITS;
         PIE_SEL_CFG: rd_word = {16'h0000, cfg_r & PIE_CFG_WBITS};
         PIE_SEL_CNT: rd_word = {16'h0000, cnt_r}; // see R18
         default: rd_word = 32'h0000_0000;
      endcase
   end

   assign mask_wr = commit && (sel_r == PIE_SEL_MASK);
   assign cfg_wr = commit && (sel_r == PIE_SEL_CFG);
   assign cnt_wr = commit && (sel_r == PIE_SEL_CNT);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sel_r <= PIE_SEL_NONE;
         rd_dir_r <= 1'b0;
         idx_r <= 3'h0;
         asm_r <= 32'h0000_0000;
      end else if (i_wr_valid && i_wr_is_code) begin
         sel_r <= code_sel;
         rd_dir_r <= code_rd;
         idx_r <= 3'h0; // see R23
         asm_r <= 32'h0000_0000;
      end else if (data_wr || data_rd) begin
         idx_r <= idx_r + 3'h1; // see R23
         if (data_wr) begin
            asm_r <= wr_word;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_data_r <= 8'h00;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= i_rd_req;
         if (data_rd) begin
            rd_data_r <= rd_word[{idx_r[1:0], 3'h0} +: 8]; // see R23
         end else begin
            rd_data_r <= 8'h00;
         end
      end
   end

   // Bus reset has no term here, so programmed enables survive it
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mask_r <= PIE_MASK_RST;
      end else if (mask_wr) begin
         mask_r <= wr_word & PIE_MASK_WBITS; // see R2, R8
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_r <= PIE_CFG_RST;
      end else begin
         if (cfg_wr) begin
            cfg_r <= wr_word[15:0] & PIE_CFG_WBITS; // see R11
         end
         if (i_bus_reset) begin
            cfg_r[PIE_RUN_BIT] <= 1'b0; // see R10
         end
      end
   end

   assign run = cfg_r[PIE_RUN_BIT]; // see R11
   assign o_dma_endpt = cfg_r[PIE_EPSEL_LSB +: 4]; // see R15

   always_comb begin
      case (cfg_r[PIE_BURST_LSB +: 2]) // see R16
         2'h0: o_burst_bytes = 5'h01;
         2'h1: o_burst_bytes = 5'h04;
         2'h2: o_burst_bytes = 5'h08;
         default: o_burst_bytes = 5'h10;
      endcase
   end

   // Endpoint side: drop the packet length word, then queue bytes
   assign fifo_bus.flush = !run; // see R11
   assign fifo_bus.push_valid = i_ep_valid && run && (skip_r == 2'h0);
   assign fifo_bus.push_data = i_ep_data;
   assign o_ep_ready = run && ((skip_r != 2'h0) || fifo_bus.push_ready);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         skip_r <= PIE_SKIP_BYTES;
      end else if (i_ep_start || !run) begin
         skip_r <= PIE_SKIP_BYTES; // see R21
      end else if (i_ep_valid && (skip_r != 2'h0)) begin
         skip_r <= skip_r - 2'h1; // see R21
      end
   end

   // DMA side: stall drains when stopped; the FIFO is flushed and o_ep_ready held low by run
   assign o_dma_valid = fifo_bus.pop_valid && run;
   assign o_dma_data = fifo_bus.pop_data;
   assign fifo_bus.pop_ready = i_dma_ready && run;
   assign deliver = o_dma_valid && i_dma_ready;
   assign burst_lvl = LVLW'(o_burst_bytes);
   // Short final burst still requests once the count is nearly done
   assign o_dma_req = run && ((fifo_bus.level >= burst_lvl)
      || ((fifo_bus.level != '0)
      && ({{(16 - LVLW){1'b0}}, fifo_bus.level} >= cnt_r)));

   assign cnt_zero_eot = deliver && (cnt_r == 16'h0001)
      && cfg_r[PIE_CNTEND_BIT]; // see R12
   assign short_eot = i_ev_short && run && !i_ep_is_in
      && cfg_r[PIE_SHORT_PACKET_END_MODE_BIT]; // see R13, R14
   assign any_eot = cnt_zero_eot || short_eot || (i_ext_eot && run);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prog_r <= PIE_CNT_RST;
      end else if (cnt_wr) begin
         prog_r <= wr_word[15:0]; // see R18, R19
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_r <= PIE_CNT_RST;
      end else if (cnt_wr) begin
         cnt_r <= wr_word[15:0]; // see R18
      end else if (any_eot) begin
         cnt_r <= prog_r; // see R20
      end else if (deliver && (cnt_r != 16'h0000)) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         eot_r <= 1'b0;
         partial_r <= 1'b0;
      end else begin
         eot_r <= any_eot;
         partial_r <= i_ext_eot && run && i_ep_is_in; // see R22
      end
   end

   assign o_dma_eot = eot_r;
   assign o_send_partial = partial_r;

   // Event vector lines up bit for bit with the enable mask
   assign events[PIE_EPT_MSB:PIE_EPT_LSB] = i_ev_endpt; // see R3
   assign events[7] = 1'b0;
   assign events[PIE_SHORT_BIT] = i_ev_short; // see R4
   assign events[PIE_PSOF_BIT] = i_ev_pseudo_sof; // see R5
   assign events[PIE_SOF_BIT] = i_ev_sof; // see R6
   assign events[PIE_EOT_BIT] = eot_r; // see R6
   assign events[PIE_SUSP_BIT] = i_ev_suspend; // see R7
   assign events[PIE_RESM_BIT] = i_ev_resume; // see R7
   assign events[PIE_BRST_BIT] = i_bus_reset; // see R7

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(events & mask_r[23:0]); // see R24
      end
   end

   assign o_irq = irq_r;
   assign o_rd_data = rd_data_r;
   assign o_rd_valid = rd_valid_r;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   mask_keep_a: assert property (i_bus_reset && !mask_wr // see R2
      |=> $stable(mask_r))
      else $error("mask changed by bus reset");
   run_clear_a: assert property (i_bus_reset |=> !run) // see R10
      else $error("run bit survived bus reset");
   cfg_keep_a: assert property (i_bus_reset && !cfg_wr // see R10
      |=> cfg_r[15:4] == $past(cfg_r[15:4])
      && cfg_r[2:0] == $past(cfg_r[2:0]))
      else $error("config bits changed by bus reset");
   irq_gate_a: assert property (o_irq // see R24
      |-> $past(|(events & mask_r[23:0])))
      else $error("interrupt without enabled event");
   ept_irq_a: assert property (i_ev_endpt[1] && mask_r[9] // see R3
      |=> o_irq)
      else $error("control IN event lost");
   cnt_eot_a: assert property (deliver && cnt_r == 16'h0001 // see R12
      && cfg_r[PIE_CNTEND_BIT] |=> o_dma_eot ##1 !o_dma_eot)
      else $error("no end of transfer at zero count");
   short_eot_a: assert property (i_ev_short && run && !i_ep_is_in // see R13
      && cfg_r[PIE_SHORT_PACKET_END_MODE_BIT] |=> o_dma_eot)
      else $error("short packet end missing");
   reload_a: assert property (any_eot && !cnt_wr // see R20
      |=> cnt_r == $past(prog_r))
      else $error("counter not reloaded");
   skip_len_a: assert property (i_ep_valid && skip_r != 2'h0 // see R21
      |-> !fifo_bus.push_valid)
      else $error("length byte queued");
   rd_cnt_a: assert property (data_rd && sel_r == PIE_SEL_CNT // see R18
      && idx_r == 3'h0 |=> o_rd_valid && o_rd_data == $past(cnt_r[7:0]))
      else $error("counter read wrong");
   stop_a: assert property (!run |-> !o_dma_valid && !o_dma_req) // see R11
      else $error("DMA active while stopped");
   rsv_mask_a: assert property (mask_r[31:24] == 8'h00 // see R8
      && !mask_r[7])
      else $error("reserved mask bits set");

   eot_c: cover property (run ##[1:40] o_dma_eot);
   irq_c: cover property (mask_wr ##[1:20] o_irq);
   fill_c: cover property (run && !fifo_bus.push_ready);
   partial_c: cover property (o_send_partial);
endmodule

//--- dv/pie_dma_model.sv
`timescale 1ns/100ps
module pie_dma_model (
   input wire logic i_mclk,       // Core clock
   input wire logic i_reset_n,    // Async reset, active low
   input wire logic [1:0] i_mode, // 0 fast, 1 slow, 2 stalled
   output logic o_ready           // Takes the head byte when high
);
   logic [1:0] tick_r;

   // Slow mode takes one byte in four on a fixed pace, so the FIFO
   // is sure to fill; a random pace might drain it too soon
   always @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tick_r <= 2'h0;
         o_ready <= 1'b0;
      end else begin
         tick_r <= tick_r + 2'h1;
         o_ready <= #1 (i_mode == 2'h0) ||
            (i_mode == 2'h1 && tick_r == 2'h0);
      end
   end
endmodule

//--- dv/pie_regs_test.sv
`timescale 1ns/100ps
module pie_regs_test;
   import pie_pkg::*;
   logic i_mclk, i_reset_n, i_wr_valid, i_wr_is_code, i_rd_req;
   logic [7:0] i_wr_byte, i_ep_data, o_rd_data, o_dma_data;
   logic [23:0] ev_v;
   logic i_ep_start, i_ep_is_in, i_ep_valid, i_ext_eot, dma_ready;
   logic o_rd_valid, o_irq, o_ep_ready, o_dma_valid, o_dma_req;
   logic o_dma_eot, o_send_partial, irq_due, eot_due, part_due;
   logic mon_on, saw_full, take_v, new_eot;
   logic [4:0] o_burst_bytes;
   logic [3:0] o_dma_endpt;
   logic [1:0] dma_mode;
   logic [31:0] rd_v;
   logic [7:0] exp_q[$];
   int num_errors, num_checks, m_mask, m_cfg, m_prog, m_rem, lvl, bb, k;
   int seed;

   pie_regs #(.FIFO_DEPTH(16)) u_pie_regs (.i_mclk(i_mclk),
      .i_reset_n(i_reset_n), .i_wr_valid(i_wr_valid),
      .i_wr_is_code(i_wr_is_code), .i_wr_byte(i_wr_byte),
      .i_rd_req(i_rd_req), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
      .i_bus_reset(ev_v[0]), .i_ev_endpt(ev_v[23:8]),
      .i_ev_short(ev_v[6]), .i_ev_pseudo_sof(ev_v[5]), .i_ev_sof(ev_v[4]),
      .i_ev_suspend(ev_v[2]), .i_ev_resume(ev_v[1]), .o_irq(o_irq),
      .i_ep_start(i_ep_start), .i_ep_is_in(i_ep_is_in),
      .i_ep_valid(i_ep_valid), .i_ep_data(i_ep_data),
      .o_ep_ready(o_ep_ready), .o_dma_valid(o_dma_valid),
      .o_dma_data(o_dma_data), .i_dma_ready(dma_ready),
      .o_dma_req(o_dma_req), .o_burst_bytes(o_burst_bytes),
      .o_dma_endpt(o_dma_endpt), .i_ext_eot(i_ext_eot),
      .o_dma_eot(o_dma_eot), .o_send_partial(o_send_partial));

   pie_dma_model u_pie_dma_model (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_mode(dma_mode), .o_ready(dma_ready));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step;
      @(posedge i_mclk);
      #1;
   endtask

   // Byte count follows the code so a value is never sent short
   task automatic wr_reg(input logic [7:0] code, input logic [31:0] val);
      int n;
      n = (code == PIE_CODE_MASK_WR) ? 4 : 2;
      i_wr_valid = 1'b1;
      i_wr_is_code = 1'b1;
      i_wr_byte = code;
      step;
      i_wr_is_code = 1'b0;
      for (int i = 0; i < n; i++) begin
         i_wr_byte = val[8*i +: 8];
         step;
      end
      i_wr_valid = 1'b0;
      if (code == PIE_CODE_MASK_WR) m_mask = val & PIE_MASK_WBITS;
      if (code == PIE_CODE_CFG_WR) begin
         if (!val[3]) exp_q.delete();
         m_cfg = val & PIE_CFG_WBITS;
      end
      if (code == PIE_CODE_CNT_WR) begin
         m_prog = val[15:0];
         m_rem = m_prog;
      end
      // Idle cycle so the next call never raises the strobe at once
      step;
   endtask

   task automatic chk_rd(input logic [7:0] code, input logic [31:0] exp);
      int n;
      n = (code == PIE_CODE_MASK_RD) ? 4 : 2;
      rd_v = '0;
      i_wr_valid = 1'b1;
      i_wr_is_code = 1'b1;
      i_wr_byte = code;
      step;
      i_wr_valid = 1'b0;
      for (int i = 0; i < n; i++) begin
         i_rd_req = 1'b1;
         step;
         i_rd_req = 1'b0;
         @(negedge i_mclk);
         chk_flag(o_rd_valid, 1'b1);
         rd_v[8*i +: 8] = o_rd_data;
         step;
      end
      chk_reg(rd_v, exp);
   endtask

   task automatic pulse(input int b);
      ev_v[b] = 1'b1;
      step;
      ev_v = '0;
      step;
      step;
   endtask

   // Two leading length bytes, then n data bytes, each held until taken
   task automatic push_buf(input int n);
      logic r;
      int w;
      i_ep_start = 1'b1;
      step;
      i_ep_start = 1'b0;
      for (int i = 0; i < n + 2; i++) begin
         i_ep_valid = 1'b1;
         i_ep_data = $urandom;
         w = 0;
         do begin
            @(negedge i_mclk);
            r = o_ep_ready;
            if (!r && i >= 2) saw_full = 1'b1;
            @(posedge i_mclk);
            w++;
         end while (!r && w < 2000);
         #1;
         if (i >= 2) exp_q.push_back(i_ep_data);
      end
      i_ep_valid = 1'b0;
   endtask

   task automatic drain;
      for (k = 0; k < 500 && exp_q.size() != 0; k++) step;
      step;
      step;
   endtask

   always @(negedge i_mclk) begin
      if (mon_on) begin
         chk_flag(o_irq, irq_due);
         chk_flag(o_dma_eot, eot_due);
         chk_flag(o_send_partial, part_due);
         chk_flag(o_dma_valid, exp_q.size() != 0);
         bb = 1 << (m_cfg[1:0] == 0 ? 0 : m_cfg[1:0] + 1);
         chk_reg(o_burst_bytes, bb);
         chk_reg(o_dma_endpt, m_cfg[7:4]);
         lvl = exp_q.size();
         chk_flag(o_dma_req, m_cfg[3] && (lvl >= bb ||
            lvl != 0 && lvl >= m_rem));
         take_v = o_dma_valid && dma_ready;
         if (take_v && lvl != 0) begin
            chk_byte(o_dma_data, exp_q.pop_front());
         end
         new_eot = m_cfg[3] && (take_v && m_rem == 1 && m_cfg[15] ||
            i_ext_eot || ev_v[6] && m_cfg[14] && !i_ep_is_in);
         part_due = m_cfg[3] && i_ext_eot && i_ep_is_in;
         irq_due = |(ev_v & m_mask[23:0]) || eot_due && m_mask[3];
         eot_due = new_eot;
         if (take_v && m_rem > 0) m_rem--;
         if (new_eot) m_rem = m_prog;
         if (ev_v[0] && m_cfg[3]) begin
            m_cfg[3] = 1'b0;
            exp_q.delete();
         end
      end
   end

   initial begin
      #200000;
      num_errors++;
      $display("ERROR %0t watchdog expired", $time);
      test_done;
   end

   initial begin
      {i_reset_n, i_wr_valid, i_wr_is_code, i_rd_req, i_ep_start} = '0;
      {i_ep_is_in, i_ep_valid, i_ext_eot, mon_on, saw_full} = '0;
      {irq_due, eot_due, part_due} = '0;
      {i_wr_byte, i_ep_data, ev_v, dma_mode} = '0;
      {num_errors, num_checks, m_mask, m_cfg, m_prog, m_rem} = '0;
      seed = $urandom(76949);
      repeat (10) @(posedge i_mclk);
      #1;
      i_reset_n = 1'b1;
      mon_on = 1'b1;
      chk_rd(PIE_CODE_MASK_RD, PIE_MASK_RST);
      chk_rd(PIE_CODE_CFG_RD, PIE_CFG_RST);
      chk_rd(PIE_CODE_CNT_RD, PIE_CNT_RST);
      chk_rd(8'h55, 32'h0000_0000);
      for (int b = 0; b < 4; b++) begin
         wr_reg(PIE_CODE_MASK_WR, $urandom & 32'h00ff_ffff);
         wr_reg(PIE_CODE_CFG_WR, ($urandom & 32'hfff4) | 32'h8 | b);
         wr_reg(PIE_CODE_CNT_WR, $urandom & 32'hffff);
         chk_rd(PIE_CODE_MASK_RD, m_mask);
         chk_rd(PIE_CODE_CFG_RD, m_cfg);
         chk_rd(PIE_CODE_CNT_RD, m_rem);
         pulse(0);
         chk_rd(PIE_CODE_MASK_RD, m_mask);
         chk_rd(PIE_CODE_CFG_RD, m_cfg);
         chk_rd(PIE_CODE_CNT_RD, m_rem);
      end
      for (int b = 0; b < 24; b++) begin
         if (b != 3 && b != 7) begin
            wr_reg(PIE_CODE_MASK_WR, 1 << b);
            pulse(b);
            wr_reg(PIE_CODE_MASK_WR, ~(1 << b) & 32'h00ff_ffff);
            pulse(b);
         end
      end
      // Slow far side so the FIFO fills before the count runs out
      wr_reg(PIE_CODE_MASK_WR, 32'h8);
      wr_reg(PIE_CODE_CNT_WR, 24);
      wr_reg(PIE_CODE_CFG_WR, 32'h8029);
      dma_mode = 2'h1;
      push_buf(24);
      drain;
      chk_flag(saw_full, 1'b1);
      chk_rd(PIE_CODE_CNT_RD, m_rem);
      dma_mode = 2'h0;
      push_buf(5);
      drain;
      chk_rd(PIE_CODE_CNT_RD, m_rem);
      i_ep_is_in = 1'b1;
      i_ext_eot = 1'b1;
      step;
      i_ext_eot = 1'b0;
      step;
      step;
      chk_rd(PIE_CODE_CNT_RD, m_rem);
      wr_reg(PIE_CODE_CFG_WR, 32'h4008);
      wr_reg(PIE_CODE_MASK_WR, 32'h48);
      pulse(6);
      i_ep_is_in = 1'b0;
      pulse(6);
      dma_mode = 2'h2;
      push_buf(6);
      wr_reg(PIE_CODE_CFG_WR, 32'h0000);
      chk_rd(PIE_CODE_CFG_RD, m_cfg);
      dma_mode = 2'h0;
      repeat (3) step;
      test_done;
   end
endmodule
